/* File: logic/arc_pkg.sv */
package arc_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] MODE_OFF   = 8'h04;
  localparam logic [7:0] DEAD1P_OFF = 8'h08;
  localparam logic [7:0] DEAD3A_OFF = 8'h0C;
  localparam logic [7:0] DEAD3B_OFF = 8'h10;
  localparam logic [7:0] EXT_OFF    = 8'h14;
  localparam logic [7:0] RST_OFF    = 8'h18;
  localparam logic [7:0] INC_OFF    = 8'h1C;
  localparam logic [7:0] HOLD_OFF   = 8'h20;
  localparam logic [7:0] XFER_OFF   = 8'h24;
  localparam logic [7:0] STAT_OFF   = 8'h28;
  // ctrl fields
  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_XF12_BIT  = 1;
  localparam int CTRL_XF21_BIT  = 2;
  localparam int CTRL_FAIL1_BIT = 3;
  localparam int CTRL_FAIL2_BIT = 4;
  localparam int CTRL_BLK1_BIT  = 5;
  localparam int CTRL_BLK2_BIT  = 6;
  // mode register fields
  localparam int MODE_LSB = 0;
  localparam int SEQ_LSB  = 4;
  localparam int SHOT_LSB = 8;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] MODE_RST = 32'h0000_0103;
  localparam logic [15:0] TIME_RST = 16'h0064;
  // timing
  localparam int CLK_HZ       = 20_000_000;
  localparam int TICK_MS      = 1;
  localparam int TICK_CYC     = CLK_HZ / 1000 * TICK_MS;
  localparam int OPEN_WAIT_MS = 30;
  localparam int FORCE_MS     = 8;
  localparam int TW           = 16;
  typedef enum logic [1:0] {
    ARC_M13, ARC_M1P, ARC_M3A, ARC_M3B
  } arc_mode_t;
  typedef enum logic [2:0] {
    ARC_S1, ARC_S2, ARC_S12B, ARC_S1T2, ARC_S2T1
  } arc_seq_t;
endpackage

/* File: logic/arc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module arc_timer #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         resetn,
  // control
  input  wire logic         tick,
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic         hold,
  input  wire logic [W-1:0] load,
  // status
  output logic              running,
  output logic              expired
);
  logic [W-1:0] cnt_q;

  // start loads the configured duration; stop wins over a pending count
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cnt_q   <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (stop) begin
        running <= 1'b0;
      end else if (start) begin
        cnt_q   <= load;
        running <= 1'b1;
      end else if (running && tick && !hold) begin
        if (cnt_q <= W'(1)) begin
          running <= 1'b0;
          expired <= 1'b1;
        end else begin
          cnt_q <= cnt_q - W'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: logic/arc_seq.sv */
`timescale 1ns/1ps
`default_nettype none
module arc_seq #(
  parameter int TICK_CYC = arc_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // protection inputs (asynchronous)
  input  wire logic        single_pole_initiate,
  input  wire logic        three_pole_initiate,
  input  wire logic        three_pole_delayed_initiate,
  input  wire logic        multiphase_fault_input,
  input  wire logic        block_input,
  input  wire logic        reclose_pause_input,
  input  wire logic        reclose_reset_input,
  input  wire logic        manual_close_input,
  input  wire logic        extend_first_dead_time,
  input  wire logic        one_pole_open_input,
  input  wire logic        three_pole_open_input,
  // breaker inputs (asynchronous)
  input  wire logic        first_breaker_block,
  input  wire logic        second_breaker_block,
  input  wire logic [1:0]  breaker_any_open,
  input  wire logic [1:0]  breakers_closed_input,
  input  wire logic [1:0]  breaker_out_of_service,
  // outputs
  output logic [1:0]       close_cmd,
  output logic             force_three_pole_trip,
  output logic             extended_zone_one,
  output logic             reclose_in_progress,
  output logic             lockout_state
);
  localparam int NI = 17;
  localparam logic [15:0] OPEN_MS  = 16'(arc_pkg::OPEN_WAIT_MS);
  localparam logic [15:0] FORCE_T  = 16'(arc_pkg::FORCE_MS);

  // two-stage synchronisers
  logic [NI-1:0] raw, s1_q, s2_q;
  assign raw = {single_pole_initiate, three_pole_initiate,
                three_pole_delayed_initiate, multiphase_fault_input,
                block_input, reclose_pause_input, reclose_reset_input,
                manual_close_input, extend_first_dead_time,
                one_pole_open_input, three_pole_open_input,
                first_breaker_block, second_breaker_block,
                breaker_any_open, breakers_closed_input};
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic i1p, i3p, i3d, mpf, blk, pause, rst_in, man, ext, op1, op3;
  logic blk1, blk2;
  logic [1:0] anyopen, closed;
  assign {i1p, i3p, i3d, mpf, blk, pause, rst_in, man, ext, op1, op3,
          blk1, blk2, anyopen, closed} = s2_q;
  logic [1:0] oos_q1, oos_q2;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      oos_q1 <= '0;
      oos_q2 <= '0;
    end else begin
      oos_q1 <= breaker_out_of_service;
      oos_q2 <= oos_q1;
    end
  end

  // registers
  logic [31:0] ctrl_q, mode_q;
  logic [15:0] t1p_q, t3a_q, t3b_q, text_q, trst_q, tinc_q, thold_q, txf_q;
  logic [1:0]  md;
  logic [2:0]  sq;
  logic [3:0]  max_shots;
  assign md        = mode_q[arc_pkg::MODE_LSB +: 2];
  assign sq        = mode_q[arc_pkg::SEQ_LSB +: 3];
  assign max_shots = mode_q[arc_pkg::SHOT_LSB +: 4];

  // millisecond tick
  logic [$clog2(TICK_CYC)-1:0] div_q;
  logic tick;
  assign tick = (div_q == ($clog2(TICK_CYC))'(TICK_CYC - 1));
  always_ff @(posedge sys_clk) begin
    if (!resetn) div_q <= '0;
    else if (tick) div_q <= '0;
    else div_q <= div_q + 1'b1;
  end

  typedef enum logic [2:0] {
    ST_RESET, ST_RIP, ST_DEAD, ST_CLOSE, ST_LOCK, ST_HOLD
  } arc_state_t;
  arc_state_t st_q;
  logic [3:0] shot_counter;
  logic       enabled, init_any, first_b2, sec_q, dead_b_q, pend_q;
  logic       ddead_ok, dead_run, dead_exp, rst_run, rst_exp, inc_exp;
  logic       hold_exp, xf_run, xf_exp, f_exp, go_close, three_mode;
  logic [1:0] inhibit_q, inh_exp, inh_run, blksel, cl_mask;
  logic [15:0] dead_load;

  assign enabled  = ctrl_q[arc_pkg::CTRL_EN_BIT] && !blk;
  assign init_any = i1p || i3p || i3d;
  assign first_b2 = (arc_pkg::arc_seq_t'(sq) == arc_pkg::ARC_S2T1) ||
                    (arc_pkg::arc_seq_t'(sq) == arc_pkg::ARC_S2);
  assign blksel   = {blk2 && ctrl_q[arc_pkg::CTRL_BLK2_BIT],
                     blk1 && ctrl_q[arc_pkg::CTRL_BLK1_BIT]};
  assign three_mode = (arc_pkg::arc_mode_t'(md) == arc_pkg::ARC_M3A) ||
                      (arc_pkg::arc_mode_t'(md) == arc_pkg::ARC_M3B);

  // dead time choice: single pole or timer one/two
  always_comb begin
    if (dead_b_q) dead_load = t3b_q;
    else if (pend_q) dead_load = t1p_q;
    else dead_load = t3a_q;
    if (ext && shot_counter == 4'h0)
      dead_load = dead_load + text_q;
  end
  assign ddead_ok = pend_q ? op1 : op3;

  // close target mask per sequence
  always_comb begin
    unique case (arc_pkg::arc_seq_t'(sq))
      arc_pkg::ARC_S1:   cl_mask = 2'b01;
      arc_pkg::ARC_S2:   cl_mask = 2'b10;
      arc_pkg::ARC_S12B: cl_mask = 2'b11;
      arc_pkg::ARC_S1T2: cl_mask = sec_q ? 2'b10 : 2'b01;
      default:           cl_mask = sec_q ? 2'b01 : 2'b10;
    endcase
  end

  logic blocked_first, xf_ok;
  assign blocked_first = first_b2 ? blksel[1] : blksel[0];
  assign xf_ok = first_b2 ? ctrl_q[arc_pkg::CTRL_XF21_BIT]
                          : ctrl_q[arc_pkg::CTRL_XF12_BIT];
  assign go_close = (st_q == ST_DEAD) && dead_exp;

  logic lock_ev, inc_start, close_fail_lock, pend_x_q;
  logic sequential;
  assign sequential = (arc_pkg::arc_seq_t'(sq) == arc_pkg::ARC_S1T2) ||
                      (arc_pkg::arc_seq_t'(sq) == arc_pkg::ARC_S2T1);
  logic bad_3p, m3a;
  assign m3a    = (arc_pkg::arc_mode_t'(md) == arc_pkg::ARC_M3A);
  // three-pole initiate is refused in both single-fault modes
  assign bad_3p = (i3p && ((arc_pkg::arc_mode_t'(md) == arc_pkg::ARC_M1P) ||
                  m3a)) || (m3a && mpf);
  // every in-service breaker closed at reset expiry
  logic bkr_ok;
  assign bkr_ok = &(closed | oos_q2);

  assign inc_start = (st_q == ST_RESET || st_q == ST_CLOSE) && init_any;

  // sequencer
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_q         <= ST_RESET;
      shot_counter <= 4'h0;
      sec_q        <= 1'b0;
      dead_b_q     <= 1'b0;
      pend_q       <= 1'b0;
      close_cmd    <= 2'b00;
    end else if (rst_in) begin
      st_q         <= ST_RESET;
      shot_counter <= 4'h0;
      close_cmd    <= 2'b00;
      sec_q        <= 1'b0;
    end else if (man && st_q != ST_HOLD) begin
      st_q      <= ST_HOLD;
      close_cmd <= 2'b00;
    end else begin
      unique case (st_q)
        ST_RESET, ST_CLOSE: begin
          if (st_q == ST_CLOSE && (closed & close_cmd) == close_cmd)
            close_cmd <= 2'b00;
          if (st_q == ST_CLOSE && pend_x_q) begin
            // transfer time ran out: hand the close to the other breaker
            close_cmd <= ~cl_mask;
            sec_q     <= 1'b1;
          end
          if (init_any) begin
            close_cmd <= 2'b00;
            if (shot_counter >= max_shots || bad_3p || !enabled)
              st_q <= ST_LOCK;
            else begin
              st_q     <= ST_RIP;
              pend_q   <= i1p && !i3p && !i3d;
              dead_b_q <= i3d || shot_counter != 4'h0 || pause;
            end
          end else if (st_q == ST_CLOSE && rst_exp) begin
            if (bkr_ok) begin
              st_q         <= ST_RESET;
              shot_counter <= 4'h0;
              sec_q        <= 1'b0;
            end else if (sequential && !sec_q && !close_fail_lock) begin
              // first breaker failed: continue on the other
              sec_q        <= 1'b1;
              shot_counter <= shot_counter - 4'h1;
              st_q         <= ST_DEAD;
            end else begin
              st_q <= ST_LOCK;
            end
          end
        end
        ST_RIP, ST_DEAD: begin
          if (blk || inc_exp) st_q <= ST_LOCK;
          else if (pause) dead_b_q <= 1'b1;
          else if (st_q == ST_RIP && ddead_ok) st_q <= ST_DEAD;
          else if (go_close) begin
            if (sequential && blocked_first && !sec_q) begin
              if (xf_ok) sec_q <= 1'b1;
            end else if ((cl_mask & ~blksel & ~inhibit_q) != 2'b00) begin
              close_cmd    <= cl_mask & ~blksel & ~inhibit_q;
              shot_counter <= shot_counter + 4'h1;
              st_q         <= ST_CLOSE;
            end
          end
        end
        ST_LOCK: close_cmd <= 2'b00;
        ST_HOLD: begin
          if (init_any) st_q <= ST_LOCK;
          else if (hold_exp) begin
            st_q         <= ST_RESET;
            shot_counter <= 4'h0;
          end
        end
        default: st_q <= ST_LOCK;
      endcase
    end
  end
  assign close_fail_lock = first_b2 ? ctrl_q[arc_pkg::CTRL_FAIL2_BIT]
                                    : ctrl_q[arc_pkg::CTRL_FAIL1_BIT];
  assign lock_ev = (st_q == ST_LOCK);

  // transfer in sequential order once the transfer time runs out after the first close command
  always_ff @(posedge sys_clk) begin
    if (!resetn) pend_x_q <= 1'b0;
    else pend_x_q <= xf_exp && sequential && !sec_q;
  end
  logic cmd_issue;
  assign cmd_issue = go_close && st_q == ST_DEAD;

  // timers, all counted in ms ticks
  arc_timer u_dead (.sys_clk(sys_clk), .resetn(resetn), .tick(tick),
    .start(st_q == ST_RIP && ddead_ok && !pause),
    .stop(st_q != ST_DEAD && st_q != ST_RIP), .hold(pause),
    .load(dead_load), .running(dead_run), .expired(dead_exp));
  arc_timer u_inc (.sys_clk(sys_clk), .resetn(resetn), .tick(tick),
    .start(inc_start), .hold(1'b0),
    .stop((st_q == ST_CLOSE && !init_any) || lock_ev),
    .load(tinc_q), .running(), .expired(inc_exp));
  arc_timer u_rst (.sys_clk(sys_clk), .resetn(resetn), .tick(tick),
    .start(st_q != ST_CLOSE && close_cmd != 2'b00 || cmd_issue),
    .stop(init_any || lock_ev || man || rst_in), .hold(1'b0),
    .load(trst_q), .running(rst_run), .expired(rst_exp));
  arc_timer u_hold (.sys_clk(sys_clk), .resetn(resetn), .tick(tick),
    .start(man), .stop(st_q != ST_HOLD && !man), .hold(1'b0),
    .load(thold_q), .running(), .expired(hold_exp));
  arc_timer u_xf (.sys_clk(sys_clk), .resetn(resetn), .tick(tick),
    .start(cmd_issue && sequential), .stop(init_any), .hold(1'b0),
    .load(txf_q), .running(xf_run), .expired(xf_exp));
  arc_timer u_frc (.sys_clk(sys_clk), .resetn(resetn), .tick(tick),
    .start(inc_start && i1p), .hold(1'b0),
    .stop((st_q == ST_RESET && !init_any) || lock_ev),
    .load(FORCE_T), .running(), .expired(f_exp));

  // open-before-fault inhibit per breaker
  genvar g;
  for (g = 0; g < 2; g++) begin : g_inh
    logic open_d_q;
    always_ff @(posedge sys_clk) begin
      if (!resetn) open_d_q <= 1'b0;
      else open_d_q <= anyopen[g];
    end
    arc_timer u_open (.sys_clk(sys_clk), .resetn(resetn), .tick(tick),
      .start(anyopen[g] && !open_d_q), .stop(reclose_in_progress),
      .hold(1'b0), .load(OPEN_MS), .running(inh_run[g]),
      .expired(inh_exp[g]));
    always_ff @(posedge sys_clk) begin
      if (!resetn) inhibit_q[g] <= 1'b0;
      else if (inh_exp[g]) inhibit_q[g] <= 1'b1;
      else if (closed[g]) inhibit_q[g] <= 1'b0;
    end
  end

  // force trip latch: set 8 ms after single-pole start
  logic force_q;
  always_ff @(posedge sys_clk) begin
    if (!resetn) force_q <= 1'b0;
    else if (f_exp) force_q <= 1'b1;
    else if (st_q == ST_RESET || lock_ev) force_q <= 1'b0;
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      force_three_pole_trip <= 1'b1;
      extended_zone_one     <= 1'b0;
      reclose_in_progress   <= 1'b0;
      lockout_state         <= 1'b0;
    end else begin
      force_three_pole_trip <= !enabled || lock_ev || three_mode ||
                               shot_counter != 4'h0 || force_q;
      extended_zone_one <= enabled && st_q != ST_LOCK &&
                           st_q != ST_HOLD && shot_counter == 4'h0;
      reclose_in_progress <= st_q == ST_RIP || st_q == ST_DEAD;
      lockout_state <= lock_ev;
    end
  end

  // axi4-lite slave: one-cycle response once both halves seen
  logic aw_q, w_q;
  logic [7:0]  awa_q;
  logic [31:0] wd_q;
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  logic wr_go;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  logic wr_hit;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 8'h00; wd_q <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1; awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1; wd_q <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_q <= 1'b0; w_q <= 1'b0; s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end
  assign wr_hit = awa_q <= arc_pkg::XFER_OFF && awa_q[1:0] == 2'b00;
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ctrl_q <= arc_pkg::CTRL_RST; mode_q <= arc_pkg::MODE_RST;
      t1p_q <= arc_pkg::TIME_RST; t3a_q <= arc_pkg::TIME_RST;
      t3b_q <= arc_pkg::TIME_RST; text_q <= arc_pkg::TIME_RST;
      trst_q <= arc_pkg::TIME_RST; tinc_q <= arc_pkg::TIME_RST;
      thold_q <= arc_pkg::TIME_RST; txf_q <= arc_pkg::TIME_RST;
    end else if (wr_go) begin
      unique case (awa_q)
        arc_pkg::CTRL_OFF:   ctrl_q  <= wd_q;
        arc_pkg::MODE_OFF:   mode_q  <= wd_q;
        arc_pkg::DEAD1P_OFF: t1p_q   <= wd_q[15:0];
        arc_pkg::DEAD3A_OFF: t3a_q   <= wd_q[15:0];
        arc_pkg::DEAD3B_OFF: t3b_q   <= wd_q[15:0];
        arc_pkg::EXT_OFF:    text_q  <= wd_q[15:0];
        arc_pkg::RST_OFF:    trst_q  <= wd_q[15:0];
        arc_pkg::INC_OFF:    tinc_q  <= wd_q[15:0];
        arc_pkg::HOLD_OFF:   thold_q <= wd_q[15:0];
        arc_pkg::XFER_OFF:   txf_q   <= wd_q[15:0];
        default: ;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      unique case (s_axi_araddr)
        arc_pkg::CTRL_OFF:   s_axi_rdata <= ctrl_q;
        arc_pkg::MODE_OFF:   s_axi_rdata <= mode_q;
        arc_pkg::DEAD1P_OFF: s_axi_rdata <= {16'h0000, t1p_q};
        arc_pkg::DEAD3A_OFF: s_axi_rdata <= {16'h0000, t3a_q};
        arc_pkg::DEAD3B_OFF: s_axi_rdata <= {16'h0000, t3b_q};
        arc_pkg::EXT_OFF:    s_axi_rdata <= {16'h0000, text_q};
        arc_pkg::RST_OFF:    s_axi_rdata <= {16'h0000, trst_q};
        arc_pkg::INC_OFF:    s_axi_rdata <= {16'h0000, tinc_q};
        arc_pkg::HOLD_OFF:   s_axi_rdata <= {16'h0000, thold_q};
        arc_pkg::XFER_OFF:   s_axi_rdata <= {16'h0000, txf_q};
        arc_pkg::STAT_OFF:   s_axi_rdata <= {16'h0000, 1'b0, st_q,
          shot_counter, inhibit_q, close_cmd, dead_run, rst_run,
          lockout_state, reclose_in_progress};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

/* File: tb/arc_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module arc_chk (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       resetn,
  // causes
  input wire logic       reclose_reset_input,
  input wire logic       manual_close_input,
  input wire logic       single_pole_initiate,
  input wire logic       three_pole_initiate,
  // results
  input wire logic [1:0] close_cmd,
  input wire logic       force_three_pole_trip,
  input wire logic       extended_zone_one,
  input wire logic       reclose_in_progress,
  input wire logic       lockout_state
);
  // history spans the two-flop input synchroniser
  logic [5:0] rel_q;
  logic [5:0] ini_q;
  always_ff @(posedge sys_clk) begin
    rel_q <= {rel_q[4:0], reclose_reset_input | manual_close_input};
  end
  always_ff @(posedge sys_clk) begin
    ini_q <= {ini_q[4:0], single_pole_initiate | three_pole_initiate};
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  lock_no_rip_a: assert property (lockout_state [*2] |-> !reclose_in_progress)
    else $error("progress shown in lockout");
  lock_force_a: assert property (lockout_state [*2] |-> force_three_pole_trip)
    else $error("no forced trip in lockout");
  lock_zone_a: assert property (lockout_state [*2] |-> !extended_zone_one)
    else $error("zone one extended in lockout");
  close_zone_a: assert property ($rose(|close_cmd) |-> ##[0:2] !extended_zone_one)
    else $error("zone one kept after close");
  close_force_a: assert property ($rose(|close_cmd) |-> ##[0:2] force_three_pole_trip)
    else $error("no forced trip with shots taken");
  lock_latch_a: assert property ($fell(lockout_state) |-> |rel_q)
    else $error("lockout left without release");
  rip_cause_a: assert property ($rose(reclose_in_progress) |-> |ini_q)
    else $error("progress without initiate");
  rip_end_a: assert property ($fell(reclose_in_progress) && !(|rel_q)
    |-> ##[0:2] (close_cmd != 2'h0 || lockout_state))
    else $error("progress dropped without close");
  reset_in_a: assert property (reclose_reset_input [*4]
    |-> ##[0:2] !lockout_state && !reclose_in_progress)
    else $error("reset input ignored");
  cover property ($rose(|close_cmd));
  cover property ($rose(lockout_state));
  cover property ($fell(lockout_state));
endmodule
bind arc_seq arc_chk u_chk (.sys_clk, .resetn, .reclose_reset_input,
  .manual_close_input, .single_pole_initiate, .three_pole_initiate,
  .close_cmd, .force_three_pole_trip, .extended_zone_one,
  .reclose_in_progress, .lockout_state);
`default_nettype wire

/* File: tb/arc_brk.sv */
`timescale 1ns/1ps
`default_nettype none
module arc_brk #(
  parameter int CLOSE_CYC = 10
) (
  // clock
  input wire logic        sys_clk,
  // commands, trip bit0 single pole, bit1 three pole
  input wire logic [1:0]  trip,
  input wire logic        man,
  input wire logic [1:0]  close_cmd,
  // status, breaker two stays open and out of service
  output logic [1:0]      any_open,
  output logic [1:0]      closed,
  output logic            one_open,
  output logic            three_open
);
  logic       open_q = 1'b0;
  logic [1:0] kind_q = 2'h0;
  logic [7:0] cnt_q  = 8'h00;
  // closes after a closing time of command cycles (count not cleared when the command drops), or at once on man
  always_ff @(posedge sys_clk) begin
    if (trip != 2'h0) begin
      open_q <= 1'b1;
      kind_q <= trip;
      cnt_q  <= 8'h00;
    end else if (man) begin
      open_q <= 1'b0;
    end else if (close_cmd[0] && open_q) begin
      cnt_q <= cnt_q + 8'h01;
      if (cnt_q == 8'(CLOSE_CYC)) open_q <= 1'b0;
    end
  end
  assign any_open   = {1'b1, open_q};
  assign closed     = {1'b0, !open_q};
  assign one_open   = open_q & kind_q[0];
  assign three_open = open_q & kind_q[1];
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0000_0000;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, spi = 1'b0, tpi = 1'b0;
  logic        blk = 1'b0, rst_in = 1'b0, man = 1'b0;
  logic [1:0]  trip = 2'h0;
  logic [1:0]  oos  = 2'h2;
  wire logic   awready, wready, bvalid, arready, rvalid, o1, o3;
  wire logic   f3p, ez1, rip, lo;
  wire logic [1:0]  bresp, rresp, cc, aop, cls;
  wire logic [31:0] rdata;
  int          failures  = 0;
  int          cmp_count = 0;
  logic [31:0] d;
  logic [1:0]  r;
  always #25 sys_clk = ~sys_clk;
  arc_seq #(.TICK_CYC(20)) dut (.sys_clk, .resetn, .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .single_pole_initiate(spi),
    .three_pole_initiate(tpi), .three_pole_delayed_initiate(1'b0),
    .multiphase_fault_input(tpi), .block_input(blk),
    .reclose_pause_input(1'b0), .reclose_reset_input(rst_in),
    .manual_close_input(man), .extend_first_dead_time(1'b0),
    .one_pole_open_input(o1), .three_pole_open_input(o3),
    .first_breaker_block(blk), .second_breaker_block(blk),
    .breaker_any_open(aop), .breakers_closed_input(cls),
    .breaker_out_of_service(oos), .close_cmd(cc),
    .force_three_pole_trip(f3p), .extended_zone_one(ez1),
    .reclose_in_progress(rip), .lockout_state(lo));
  arc_brk brk (.sys_clk, .trip, .man, .close_cmd(cc), .any_open(aop),
    .closed(cls), .one_open(o1), .three_open(o3));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge sys_clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
    do begin
      @(negedge sys_clk);
      {ta, tw, tb} = {awready & awvalid, wready & wvalid, bvalid};
      @(posedge sys_clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!tb);
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    logic ta, tr;
    @(posedge sys_clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do begin
      @(negedge sys_clk);
      {ta, tr, d, r} = {arready & arvalid, rvalid, rdata, rresp};
      @(posedge sys_clk);
      if (ta) arvalid <= 1'b0;
    end while (!tr);
    rready <= 1'b0;
  endtask
  // each fault trips breaker one single pole, dead time 14 ticks (14 us with TICK_CYC 20)
  task fault;
    @(posedge sys_clk);
    {spi, trip} <= 3'h5;
    @(posedge sys_clk);
    trip <= 2'h0;
    for (int i = 0; i < 9 && !rip; i++) @(negedge sys_clk);
    @(posedge sys_clk);
    spi <= 1'b0;
  endtask
  task t_regs;
    rd(arc_pkg::CTRL_OFF); chk(d, arc_pkg::CTRL_RST);
    rd(arc_pkg::MODE_OFF); chk(d, arc_pkg::MODE_RST);
    rd(arc_pkg::RST_OFF); chk(d, 32'(arc_pkg::TIME_RST));
    rd(8'h40); chk(r, 2'h2);
    chk(f3p, 1'h1);
    chk(ez1, 1'h1);
    wr(arc_pkg::MODE_OFF, 32'h0000_0100);
    wr(arc_pkg::DEAD1P_OFF, 32'h0000_000e);
    wr(arc_pkg::RST_OFF, 32'h0000_0003);
    wr(arc_pkg::INC_OFF, 32'h0000_001e);
    wr(arc_pkg::HOLD_OFF, 32'h0000_0002);
    @(negedge sys_clk); chk(f3p, 1'h0);
    $display("registers done");
  endtask
  task t_cycle;
    fault; chk(rip, 1'h1);
    repeat (200) @(negedge sys_clk);
    chk(f3p, 1'h1);
    chk(cc, 2'h0);
    for (int i = 0; i < 200 && !cc[0]; i++) @(negedge sys_clk);
    chk(cc, 2'h1);
    repeat (3) @(negedge sys_clk);
    chk(rip, 1'h0);
    chk(ez1, 1'h0);
    for (int i = 0; i < 200 && !ez1; i++) @(negedge sys_clk);
    chk(lo, 1'h0);
    rd(arc_pkg::STAT_OFF); chk(d[11:8], 4'h0);
    fault;
    for (int i = 0; i < 400 && !cc[0]; i++) @(negedge sys_clk);
    fault;
    repeat (90) @(negedge sys_clk);
    chk(lo, 1'h1);
    chk(ez1, 1'h0);
    @(posedge sys_clk);
    {spi, rst_in} <= 2'h1;
    repeat (9) @(negedge sys_clk);
    chk(lo, 1'h0);
    @(posedge sys_clk);
    rst_in <= 1'b0;
    $display("reclose cycle done");
  endtask
  task t_block;
    @(posedge sys_clk); man <= 1'b1;
    @(posedge sys_clk); man <= 1'b0;
    repeat (9) @(negedge sys_clk); chk(ez1, 1'h0);
    repeat (90) @(negedge sys_clk); chk(ez1, 1'h1);
    @(posedge sys_clk); spi <= 1'b1;
    repeat (9) @(posedge sys_clk); blk <= 1'b1;
    repeat (9) @(negedge sys_clk); chk(lo, 1'h1);
    @(posedge sys_clk);
    {spi, blk, man} <= 3'h1;
    @(posedge sys_clk); man <= 1'b0;
    repeat (9) @(negedge sys_clk); chk(lo, 1'h0);
    repeat (90) @(negedge sys_clk);
    $display("block done");
  endtask
  task t_mode;
    wr(arc_pkg::MODE_OFF, 32'h0000_0101);
    tpi <= 1'b1;
    repeat (9) @(negedge sys_clk); chk(lo, 1'h1);
    @(posedge sys_clk);
    {tpi, rst_in} <= 2'h1;
    repeat (9) @(posedge sys_clk); rst_in <= 1'b0;
    wr(arc_pkg::MODE_OFF, 32'h0000_0100);
    spi <= 1'b1;
    repeat (9) @(posedge sys_clk); spi <= 1'b0;
    repeat (500) @(negedge sys_clk); chk(lo, 1'h0);
    repeat (150) @(negedge sys_clk); chk(lo, 1'h1);
    $display("mode and timeout done");
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    t_regs;
    t_cycle;
    t_block;
    t_mode;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    wrap_up;
  end
endmodule
`default_nettype wire
